/* src/mptout_pkg.sv */
package mptout_pkg;

  // ****************************************************************
  // Clock and time base
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 4;

  // ****************************************************************
  // Pulse I/O select codes
  // ****************************************************************
  localparam logic [6:0] SEL_VOLT0   = 7'h00;
  localparam logic [6:0] SEL_VOLT1   = 7'h01;
  localparam logic [6:0] SEL_HALF0   = 7'h0A;
  localparam logic [6:0] SEL_HALF1   = 7'h0B;
  localparam logic [6:0] SEL_FIXED0  = 7'h14;
  localparam logic [6:0] SEL_FIXED1  = 7'h15;
  localparam logic [6:0] SEL_PASS    = 7'h64;
  localparam logic [6:0] SEL_RESET   = 7'h00;

  // ****************************************************************
  // Monitor item codes
  // ****************************************************************
  localparam logic [4:0] ITEM_FREQ   = 5'h01;
  localparam logic [4:0] ITEM_CURR   = 5'h02;
  localparam logic [4:0] ITEM_TORQUE = 5'h03;
  localparam logic [4:0] ITEM_REF    = 5'h15;

  // ****************************************************************
  // Pulse rates, in pulses per second
  // ****************************************************************
  localparam int unsigned VOLT_FS_PPS  = 1440;
  localparam int unsigned VOLT_MAX_PPS = 2400;
  localparam int unsigned HS_FS_PPS    = 50_000;
  localparam int unsigned HS_MAX_PPS   = 55_000;
  localparam int unsigned HS_RES_PPS   = 3;

  // Accumulator: wraps at 2^36, one phase step added per cycle
  localparam int unsigned ACC_W        = 36;
  // Rate word is pps in units of 1/16 pps (sub-resolution of 3 pps)
  localparam int unsigned RATE_FRAC    = 4;
  localparam int unsigned RATE_W       = 21;
  // Phase step per cycle = rate * 2^ACC_W / CLK_HZ; kept as a multiplier
  localparam longint unsigned STEP_MUL =
    ((64'd1 << ACC_W) + 64'(CLK_HZ) / 2) / 64'(CLK_HZ);

  // ****************************************************************
  // Pulse widths
  // ****************************************************************
  localparam int unsigned FIXED_ON_NS     = 10_000;
  localparam int unsigned FIXED_ON_CYC    = (FIXED_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] TRIM_RESET      = 16'h0FA0;
  localparam int unsigned TRIM_UNIT_NS    = 100;
  localparam int unsigned TRIM_UNIT_CYC   = TRIM_UNIT_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Analog filter
  // ****************************************************************
  localparam int unsigned AM_MIN_MS       = 4;
  localparam int unsigned AM_MIN_CYC      = AM_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned AM_STEP_MS      = 10;
  localparam int unsigned AM_STEP_CYC     = AM_STEP_MS * (CLK_HZ / 1000);
  localparam logic [8:0]  SMOOTH_MAX      = 9'h1F4;
  localparam logic [15:0] AM_FULL         = 16'hFFFF;

  // ****************************************************************
  // Full-scale reference reset values
  // ****************************************************************
  localparam logic [15:0] FREQ_FS_RESET   = 16'h1770;
  localparam logic [15:0] CURR_FS_RESET   = 16'h03E8;
  localparam logic [15:0] TORQ_FS_RESET   = 16'h05DC;
  localparam logic [15:0] FREQ_RESET_FS_SRC = 16'h1770;

  typedef enum logic [1:0] {
    MPT_VOLT  = 2'b00,
    MPT_HALF  = 2'b01,
    MPT_FIXED = 2'b11,
    MPT_PASS  = 2'b10
  } mpt_mode_t;

endpackage

/* src/mpt_monitor_out.sv */
`timescale 1ns/10ps
`default_nettype none
module mpt_monitor_out
  import mptout_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  input  wire logic        i_clk_en,
  input  wire logic [6:0]  i_pulse_io_select,
  input  wire logic        i_select_wr,
  input  wire logic        i_all_clear,
  input  wire logic [4:0]  i_pulse_out_item_select,
  input  wire logic [15:0] i_freq_full_scale_ref,
  input  wire logic [15:0] i_current_full_scale_ref,
  input  wire logic [15:0] i_torque_full_scale_ref,
  input  wire logic        i_ref_wr,
  input  wire logic        i_param_write_guard,
  input  wire logic [15:0] i_pulse_meter_trim,
  input  wire logic        i_trim_wr,
  input  wire logic [8:0]  i_analog_out_smoothing,
  input  wire logic [15:0] i_out_freq,
  input  wire logic [15:0] i_out_current,
  input  wire logic [15:0] i_out_torque,
  input  wire logic        i_pulse_input_terminal,
  output logic             o_meter_pulse_terminal,
  output logic             o_open_collector_on,
  output logic             o_high_rate_active,
  output logic             o_trim_refused,
  output logic [6:0]       o_pulse_io_select,
  output logic [15:0]      o_analog_meter_terminal
);
  import mptout_pkg::*;

  // ****************************************************************
  // Settings
  // ****************************************************************
  logic [6:0]  sel_q;
  logic [15:0] trim_q;
  logic [15:0] fs_freq_q, fs_curr_q, fs_torq_q;

  function automatic mpt_mode_t sel_mode(input logic [6:0] s);
    case (s)
      SEL_HALF0, SEL_HALF1:   sel_mode = MPT_HALF;
      SEL_FIXED0, SEL_FIXED1: sel_mode = MPT_FIXED;
      SEL_PASS:               sel_mode = MPT_PASS;
      default:                sel_mode = MPT_VOLT;
    endcase
  endfunction

  wire mpt_mode_t mode      = sel_mode(sel_q);
  wire logic      high_rate = (mode != MPT_VOLT);
  wire logic      sel_ok    = (i_pulse_io_select == SEL_VOLT0) || (i_pulse_io_select == SEL_VOLT1)
                             || (sel_mode(i_pulse_io_select) != MPT_VOLT);

  // Select register; all-clear wins over a write
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_q <= SEL_RESET;
    end else if (i_clk_en) begin
      if (i_all_clear) sel_q <= SEL_RESET;
      else if (i_select_wr && sel_ok) sel_q <= i_pulse_io_select;
    end
  end

  // Trim only taken in voltage mode; refused otherwise
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      trim_q         <= TRIM_RESET;
      o_trim_refused <= 1'b0;
    end else if (i_clk_en) begin
      if (i_trim_wr && !high_rate) trim_q <= i_pulse_meter_trim;
      o_trim_refused <= i_trim_wr && high_rate;
    end
  end

  // References take writes at any time; the guard is deliberately not read
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fs_freq_q <= FREQ_FS_RESET;
      fs_curr_q <= CURR_FS_RESET;
      fs_torq_q <= TORQ_FS_RESET;
    end else if (i_clk_en && i_ref_wr) begin
      fs_freq_q <= i_freq_full_scale_ref;
      fs_curr_q <= i_current_full_scale_ref;
      fs_torq_q <= i_torque_full_scale_ref;
    end
  end
  wire logic unused_guard = i_param_write_guard;

  // ****************************************************************
  // Monitor ratio, Q16 of full scale
  // ****************************************************************
  logic [15:0] mon_val, mon_fs;
  always_comb begin
    case (i_pulse_out_item_select)
      ITEM_CURR:   begin mon_val = i_out_current; mon_fs = fs_curr_q; end
      ITEM_TORQUE: begin mon_val = i_out_torque;  mon_fs = fs_torq_q; end
      ITEM_REF:    begin mon_val = 16'h0001;      mon_fs = 16'h0001;  end
      default:     begin mon_val = i_out_freq;    mon_fs = fs_freq_q; end
    endcase
  end

  // Sequential divider: ratio = val*2^16/fs, refreshed continuously
  logic [31:0] div_rem_q;
  logic [31:0] div_quo_q;
  logic [5:0]  div_cnt_q;
  logic [18:0] ratio_q;
  // Divisor aligned with the quotient bit decided in this step
  wire  logic [47:0] div_dsor = {32'h0, mon_fs} << (div_cnt_q - 6'h01);
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_rem_q <= 32'h0;
      div_quo_q <= 32'h0;
      div_cnt_q <= 6'h00;
      ratio_q   <= 19'h0;
    end else if (i_clk_en) begin
      if (div_cnt_q == 6'h00) begin
        div_rem_q <= {mon_val, 16'h0};
        div_quo_q <= 32'h0;
        div_cnt_q <= 6'h1D;
        ratio_q   <= (mon_fs == 16'h0) ? 19'h7FFFF :
                     (div_quo_q[31:19] != 13'h0 ? 19'h7FFFF : div_quo_q[18:0]);
      end else begin
        div_cnt_q <= div_cnt_q - 6'h01;
        if ({16'h0, div_rem_q} >= div_dsor) begin
          div_rem_q <= div_rem_q - div_dsor[31:0];
          div_quo_q <= div_quo_q | (32'h1 << (div_cnt_q - 6'h1));
        end
      end
    end
  end

  // ****************************************************************
  // Rate, scaled and clamped (units of 1/16 pps)
  // ****************************************************************
  wire logic [20:0] fs_rate  = high_rate ? 21'(HS_FS_PPS << RATE_FRAC) : 21'(VOLT_FS_PPS << RATE_FRAC);
  wire logic [20:0] max_rate = high_rate ? 21'(HS_MAX_PPS << RATE_FRAC) : 21'(VOLT_MAX_PPS << RATE_FRAC);
  wire logic [39:0] raw_rate = 40'(fs_rate) * 40'(ratio_q) >> 16;
  wire logic [20:0] rate     = (raw_rate > 40'(max_rate)) ? max_rate : raw_rate[20:0];

  // Phase step; 1/16 pps granularity is far below 3 pps
  wire logic [63:0] step_w   = 64'(rate) * STEP_MUL >> RATE_FRAC;
  logic [ACC_W-1:0] acc_q;
  wire  logic [ACC_W:0] acc_sum = {1'b0, acc_q} + {1'b0, step_w[ACC_W-1:0]};
  wire  logic       wrap     = acc_sum[ACC_W];

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) acc_q <= '0;
    else if (i_clk_en) acc_q <= acc_sum[ACC_W-1:0];
  end

  // ****************************************************************
  // Pulse shaping
  // ****************************************************************
  logic [31:0] on_cnt_q;
  logic        pin_q;
  wire  logic  in_rise = i_pulse_input_terminal & ~pin_q;
  wire  logic [31:0] volt_w  = 32'(trim_q) * 32'(TRIM_UNIT_CYC);
  wire  logic        fire    = (mode == MPT_PASS) ? in_rise : wrap;
  wire  logic [31:0] width   = (mode == MPT_VOLT) ? volt_w : 32'(FIXED_ON_CYC);
  wire  logic        half_hi = acc_q[ACC_W-1];

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      on_cnt_q <= 32'h0;
      pin_q    <= 1'b0;
    end else if (i_clk_en) begin
      pin_q <= i_pulse_input_terminal;
      if (fire) on_cnt_q <= width;
      else if (on_cnt_q != 32'h0) on_cnt_q <= on_cnt_q - 32'h1;
    end
  end

  // Outputs registered; unused terminal held off
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_meter_pulse_terminal <= 1'b0;
      o_open_collector_on    <= 1'b0;
      o_high_rate_active     <= 1'b0;
      o_pulse_io_select      <= SEL_RESET;
    end else if (i_clk_en) begin
      o_high_rate_active     <= high_rate;
      o_pulse_io_select      <= sel_q;
      o_meter_pulse_terminal <= (mode == MPT_VOLT) && (fire || on_cnt_q != 32'h0);
      o_open_collector_on    <= (mode == MPT_HALF) ? (half_hi && rate != 21'h0) :
                                (high_rate && (fire || on_cnt_q != 32'h0));
    end
  end

  // ****************************************************************
  // Analog meter output with first-order filter
  // ****************************************************************
  wire logic [15:0] am_target = (ratio_q > 19'h0FFFF) ? AM_FULL : ratio_q[15:0];
  wire logic [8:0]  smooth    = (i_analog_out_smoothing > SMOOTH_MAX) ? SMOOTH_MAX : i_analog_out_smoothing;
  // Step interval: 4 ms/16 floor, 10 ms/16 per unit; a coarse but monotonic filter
  wire logic [31:0] am_period = (smooth == 9'h0) ? 32'(AM_MIN_CYC) / 32'h10
                                : 32'(smooth) * 32'(AM_STEP_CYC) / 32'h10;
  logic [31:0] am_tick_q;
  wire  logic  am_tick = (am_tick_q >= am_period);
  wire  logic [15:0] am_diff_up = (am_target - o_analog_meter_terminal) >> 4;
  wire  logic [15:0] am_diff_dn = (o_analog_meter_terminal - am_target) >> 4;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      am_tick_q               <= 32'h0;
      o_analog_meter_terminal <= 16'h0000;
    end else if (i_clk_en) begin
      am_tick_q <= am_tick ? 32'h0 : am_tick_q + 32'h1;
      if (am_tick) begin
        if (am_target > o_analog_meter_terminal)
          o_analog_meter_terminal <= o_analog_meter_terminal + ((am_diff_up == 16'h0) ? 16'h1 : am_diff_up);
        else if (am_target < o_analog_meter_terminal)
          o_analog_meter_terminal <= o_analog_meter_terminal - ((am_diff_dn == 16'h0) ? 16'h1 : am_diff_dn);
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_clear_to_volt: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_clk_en && i_all_clear |=> sel_q == SEL_RESET) else $error("all-clear kept select");
  a_trim_refused: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_clk_en && i_trim_wr && high_rate |=> trim_q == $past(trim_q)) else $error("trim taken in high rate");
  a_volt_rate_cap: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    !high_rate |-> rate <= 21'(VOLT_MAX_PPS << RATE_FRAC)) else $error("voltage rate over cap");
  a_hs_rate_cap: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    high_rate |-> rate <= 21'(HS_MAX_PPS << RATE_FRAC)) else $error("high rate over cap");
  a_fixed_width: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_clk_en && mode == MPT_FIXED && fire |-> width == 32'(FIXED_ON_CYC)) else $error("fixed width wrong");
  a_volt_quiet_oc: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_clk_en && !high_rate |=> !o_open_collector_on) else $error("open collector on in voltage mode");
  a_hs_quiet_fm: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_clk_en && high_rate |=> !o_meter_pulse_terminal) else $error("voltage pulse in high rate");
  a_pass_copy: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_clk_en && mode == MPT_PASS && in_rise |=> o_open_collector_on) else $error("pass pulse missed");
  a_am_bounded: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    ratio_q >= 19'h10000 |-> am_target == AM_FULL) else $error("analog not clamped");

  c_volt_pulse: cover property (@(posedge i_clock) disable iff (!i_reset_n) $rose(o_meter_pulse_terminal));
  c_oc_pulse:   cover property (@(posedge i_clock) disable iff (!i_reset_n) $rose(o_open_collector_on));
  c_clear:      cover property (@(posedge i_clock) disable iff (!i_reset_n) high_rate ##1 !high_rate);
  c_refused:    cover property (@(posedge i_clock) disable iff (!i_reset_n) o_trim_refused);

endmodule
`default_nettype wire

/* verif/mpt_pulse_meter.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Pulse counter on the high-rate output, plus a pulse source
// ****************************************************************
module mpt_pulse_meter (
  input  wire logic i_clock,
  input  wire logic i_reset_n,
  input  wire logic i_line_on,
  input  var  int   i_src_period,
  output logic      o_src_pulse,
  output var  int   o_count,
  output var  int   o_src_count,
  output var  int   o_period,
  output var  int   o_width
);
  int   now;
  int   t_rise;
  int   src_t;
  logic line_q;

  // Time stamps on line edges; period and on width in clock cycles
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      now = 0;
      t_rise = 0;
      src_t = 0;
      line_q = 1'b0;
      o_count = 0;
      o_src_count = 0;
      o_period = 0;
      o_width = 0;
      o_src_pulse <= 1'b0;
    end else begin
      now = now + 1;
      if (i_line_on && !line_q) begin
        o_period = now - t_rise;
        t_rise = now;
        o_count = o_count + 1;
      end
      if (!i_line_on && line_q) o_width = now - t_rise;
      line_q = i_line_on;
      // Source train for the copy mode; quiet low when no period is set
      src_t = (src_t + 1 >= i_src_period) ? 0 : src_t + 1;
      if (i_src_period > 0 && src_t == 0) o_src_count = o_src_count + 1;
      o_src_pulse <= #1 (i_src_period > 0) && (src_t < 100);
    end
  end
endmodule
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHECK(what, exp, got) begin compares++; if ((got) !== (exp)) begin miscompares++; \
  $display("FAIL %s expected %0d seen %0d", what, exp, got); end end
module testbench;
  import mptout_pkg::*;
  logic        clk, rst_n, sel_wr, all_clr, ref_wr, guard, trim_wr, pin;
  logic        fm, oc, hra, refused;
  logic [6:0]  sel, sel_o, sel_m;
  logic [4:0]  item;
  logic [15:0] rref, mval, trim, am;
  int          src_period, cnt, scnt, per, wid, compares, miscompares;
  bit   [31:0] lfsr;
  logic [6:0]  codes [7] = '{SEL_VOLT0, SEL_VOLT1, SEL_HALF0, SEL_HALF1, SEL_FIXED0, SEL_FIXED1, SEL_PASS};
  logic [6:0]  t_sel [5] = '{SEL_HALF0, SEL_FIXED0, SEL_HALF1, SEL_FIXED1, SEL_HALF1};
  logic [4:0]  t_item [5] = '{ITEM_REF, ITEM_FREQ, ITEM_CURR, ITEM_TORQUE, ITEM_FREQ};
  int          t_val [5] = '{0, 4500, 1000, 3000, 0};
  int          t_ref [5] = '{6000, 6000, 1000, 1500, 0};

  mpt_monitor_out i_mpt_monitor_out (.i_clock(clk), .i_reset_n(rst_n), .i_clk_en(1'b1),
    .i_pulse_io_select(sel), .i_select_wr(sel_wr), .i_all_clear(all_clr), .i_pulse_out_item_select(item),
    .i_freq_full_scale_ref(rref), .i_current_full_scale_ref(rref), .i_torque_full_scale_ref(rref),
    .i_ref_wr(ref_wr), .i_param_write_guard(guard), .i_pulse_meter_trim(trim), .i_trim_wr(trim_wr),
    .i_analog_out_smoothing(9'h000), .i_out_freq(mval), .i_out_current(mval), .i_out_torque(mval),
    .i_pulse_input_terminal(pin), .o_meter_pulse_terminal(fm), .o_open_collector_on(oc),
    .o_high_rate_active(hra), .o_trim_refused(refused), .o_pulse_io_select(sel_o),
    .o_analog_meter_terminal(am));
  mpt_pulse_meter i_mpt_pulse_meter (.i_clock(clk), .i_reset_n(rst_n), .i_line_on(oc),
    .i_src_period(src_period), .o_src_pulse(pin), .o_count(cnt), .o_src_count(scnt),
    .o_period(per), .o_width(wid));

  // ****************************************************************
  // Clock, random source and bench tasks
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic bit [31:0] lfsr_next(bit [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic complete_run();
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Inputs change one ns after the edge, so the design samples them settled
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic near(string what, int e, int g);
    `CHECK(what, e, (g >= e - e / 500 - 2 && g <= e + e / 500 + 2) ? e : g)
  endtask

  // Model keeps the last accepted code; all-clear wins over the write
  task automatic write_sel(logic [6:0] code, logic clr);
    sel = code;
    sel_wr = 1'b1;
    all_clr = clr;
    if (clr) sel_m = SEL_RESET;
    else if (code inside {codes}) sel_m = code;
    tick();
    sel_wr = 1'b0;
    all_clr = 1'b0;
    // Select register, then the registered output copy: two edges
    tick();
    `CHECK("select", sel_m, sel_o)
    `CHECK("high rate", sel_m >= SEL_HALF0, hra)
  endtask

  task automatic write_trim(logic [15:0] v);
    trim = v;
    trim_wr = 1'b1;
    tick();
    trim_wr = 1'b0;
    `CHECK("trim refused", sel_m >= SEL_HALF0, refused)
  endtask

  // Three rises so the first, possibly stretched, pulse is not measured
  task automatic measure(int e_per, int e_wid);
    int c0;
    int n;
    c0 = cnt;
    n = 0;
    while (cnt < c0 + 3 && n < 40000) begin
      tick();
      n++;
    end
    if (n >= 40000) begin
      miscompares++;
      complete_run();
    end else begin
      near("period", e_per, per);
      near("on width", e_wid, wid);
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int   e_per;
    int   c0;
    longint rate;
    logic [6:0] code;
    {sel_wr, all_clr, ref_wr, guard, trim_wr} = '0;
    {sel, item, rref, mval, trim} = '0;
    src_period = 0;
    compares = 0;
    miscompares = 0;
    lfsr = 32'hFB03516E;
    sel_m = SEL_RESET;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    tick();
    `CHECK("reset select", SEL_RESET, sel_o)
    // Every code, then a random one that must be ignored
    for (int k = 0; k < 8; k++) begin
      lfsr = lfsr_next(lfsr);
      code = (k < 7) ? codes[k] : 7'(lfsr);
      if (k == 7 && (code inside {codes})) code = 7'h7F;
      write_sel(code, 1'b0);
      write_trim(lfsr[15:0]);
    end
    write_sel(SEL_FIXED0, 1'b0);
    write_sel(SEL_HALF0, 1'b1);
    write_trim(16'h0FA0);
    // Voltage mode leaves the open-collector transistor off
    item = ITEM_REF;
    write_sel(SEL_VOLT1, 1'b0);
    c0 = cnt;
    tick(3000);
    `CHECK("oc pulses", c0, cnt)
    `CHECK("fm idle before first wrap", 1'b0, fm)
    // Last entry random: value between three quarters and all of the reference
    lfsr = lfsr_next(lfsr);
    t_ref[4] = 1000 + int'(lfsr % 30000);
    lfsr = lfsr_next(lfsr);
    t_val[4] = t_ref[4] - int'(lfsr % (t_ref[4] / 4));
    for (int k = 0; k < 5; k++) begin
      lfsr = lfsr_next(lfsr);
      rref = 16'(t_ref[k]);
      mval = 16'(t_val[k]);
      item = t_item[k];
      guard = lfsr[0];
      ref_wr = 1'b1;
      tick();
      ref_wr = 1'b0;
      write_sel(t_sel[k], 1'b0);
      rate = (item == ITEM_REF) ? HS_FS_PPS : longint'(HS_FS_PPS) * t_val[k] / t_ref[k];
      if (rate > HS_MAX_PPS) rate = HS_MAX_PPS;
      e_per = int'(longint'(CLK_HZ) / rate);
      measure(e_per, (t_sel[k] inside {SEL_HALF0, SEL_HALF1}) ? e_per / 2 : FIXED_ON_CYC);
    end
    // Copy mode follows the input train's spacing
    write_sel(SEL_PASS, 1'b0);
    src_period = 5000;
    measure(5000, FIXED_ON_CYC);
    src_period = 0;
    complete_run();
  end
endmodule
`default_nettype wire
